// ### hw/dfac_top.sv
// access control, launch keying and register slave for the two flash arrays
`timescale 1ns/10ps
`include "dfac_map.svh"
// What this block does
// - user space is 256 pages of 128 bytes
// - boot flash at F800h-FFFFh while map bit set
// - separate 128-byte extra row for loader data
// - security byte: software writes upper nibble only
// - 128-byte column latch feeds every flash space
// - programming launches only from boot flash
// - software can never write the boot flash
// - access rights follow the executing region
// - main flash programmable in-system; only the security byte has a parallel write
// - maximum security blocks external code execution
// - launch needs 5xh then Axh, nothing between
// - space select picks user, extra row, security
// - busy flag held through programming, hardware cleared
// - erase loaded locations, program last loaded page
module dfac_top (
   input  wire logic        clock_in,
   input  wire logic        arst_n_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic             irq_out,
   input  wire logic        code_req_in,
   input  wire logic        code_we_in,
   input  wire logic [15:0] code_addr_in,
   input  wire logic [7:0]  code_wdata_in,
   input  wire logic [1:0]  exec_region_in,
   input  wire logic        external_access_pin_in,
   input  wire logic        boot_strap_in,
   output logic             code_ack_out,
   output logic             code_deny_out,
   output logic      [7:0]  code_rdata_out,
   input  wire logic [7:0]  main_rdata_in,
   input  wire logic [7:0]  boot_rdata_in,
   output logic             rd_boot_out,
   output logic      [1:0]  rd_space_out,
   input  wire logic        par_sec_we_in,
   input  wire logic [7:0]  par_sec_data_in,
   output logic             ext_exec_block_out,
   output logic             arr_erase_out,
   output logic             arr_prog_out,
   output logic      [1:0]  arr_space_out,
   output logic      [7:0]  arr_page_out,
   output logic      [6:0]  arr_off_out,
   output logic      [7:0]  arr_wdata_out
);
   logic        apb_acc;
   logic        apb_wr;
   logic        hit;
   logic        ctrl_wr;
   logic [3:0]  key_in;
   logic [3:0]  key_q;
   logic [3:0]  key_d;
   logic        lmap_q;
   logic        lmap_d;
   logic [1:0]  ss_q;
   logic [1:0]  ss_d;
   logic [1:0]  pspace_q;
   logic [1:0]  pspace_d;
   logic        boot_map_enable_q;
   logic        boot_map_enable_d;
   logic        strap_done_q;
   logic [7:0]  sec_q;
   logic [7:0]  sec_d;
   logic [`DFAC_ST_W-1:0] stat_q;
   logic [`DFAC_ST_W-1:0] stat_d;
   logic [`DFAC_ST_W-1:0] mask_q;
   logic [`DFAC_ST_W-1:0] mask_d;
   logic [7:0]  page_q;
   logic [7:0]  page_d;
   dfac_pkg::dfac_key_t ks_q;
   dfac_pkg::dfac_key_t ks_d;
   logic        launch;
   logic        start;
   logic        refuse;
   logic        busy;
   logic        done;
   logic [6:0]  idx;
   logic        erase;
   logic        prog;
   logic [7:0]  lat_rdata;
   logic [`DFAC_PAGE_BYTES-1:0] lat_valid;
   logic        ex_main;
   logic        ex_boot;
   logic        ex_ext;
   logic        in_boot;
   logic        in_spare_info_row;
   logic        in_sec;
   logic        ld_ok;
   logic        rd_ok;
   logic        deny;
   logic        lat_wr;
   logic [7:0]  rdata_d;
   logic [7:0]  rdata_q;
   logic        ack_q;
   logic        deny_q;

   // register slave: zero wait states, unmapped offsets flag an error
   assign apb_acc = psel_in && penable_in;
   assign apb_wr  = apb_acc && pwrite_in;
   assign hit     = (paddr_in == `DFAC_OFF_CTRL) || (paddr_in == `DFAC_OFF_AUX) ||
                    (paddr_in == `DFAC_OFF_STAT) || (paddr_in == `DFAC_OFF_MASK) ||
                    (paddr_in == `DFAC_OFF_SEC);
   assign pready_out  = 1'b1;
   assign pslverr_out = apb_acc && !hit;
   assign ctrl_wr = apb_wr && (paddr_in == `DFAC_OFF_CTRL);
   assign key_in  = pwdata_in[`DFAC_CTRL_KEYHI:`DFAC_CTRL_KEYLO];

   always_comb begin
      prdata_out = 32'h0000_0000;
      if (apb_acc && !pwrite_in) begin
         case (paddr_in)
            `DFAC_OFF_CTRL: begin
               prdata_out[`DFAC_CTRL_KEYHI:`DFAC_CTRL_KEYLO] = key_q;
               prdata_out[`DFAC_CTRL_LMAP] = lmap_q;
               prdata_out[`DFAC_CTRL_SS_HI:`DFAC_CTRL_SS_LO] = ss_q;
               prdata_out[`DFAC_CTRL_BUSY] = busy;
            end
            `DFAC_OFF_AUX:  prdata_out[`DFAC_AUX_BOOT] = boot_map_enable_q;
            `DFAC_OFF_STAT: prdata_out[`DFAC_ST_W-1:0] = stat_q;
            `DFAC_OFF_MASK: prdata_out[`DFAC_ST_W-1:0] = mask_q;
            `DFAC_OFF_SEC:  prdata_out[7:0] = sec_q;
            default:        prdata_out = 32'h0000_0000;
         endcase
      end
   end

   // executing region and decoded target
   assign ex_main = (exec_region_in == `DFAC_EX_MAIN);
   assign ex_boot = (exec_region_in == `DFAC_EX_BOOT);
   assign ex_ext  = (exec_region_in == `DFAC_EX_EXT);
   assign in_boot = boot_map_enable_q && (code_addr_in >= `DFAC_BOOT_BASE) && !in_spare_info_row;
   assign in_spare_info_row = (ss_q == `DFAC_SP_SPARE_INFO_ROW) && (code_addr_in >= `DFAC_SPARE_INFO_ROW_BASE);
   assign in_sec  = (ss_q == `DFAC_SP_SEC) && (code_addr_in == `DFAC_SEC_ADDR);
   // locked parts cannot run outside code at all
   assign ext_exec_block_out = (sec_q[3:0] == `DFAC_LOCK_MAX);

   // boot reads only from boot code; outside code with the pin low gets nothing
   always_comb begin
      rd_ok = 1'b0;
      if (ex_boot) begin
         rd_ok = 1'b1;
      end else if (ex_main) begin
         rd_ok = !in_boot;
      end else if (ex_ext) begin
         rd_ok = external_access_pin_in && !ext_exec_block_out && !in_boot;
      end
   end

   // latch loads go to the user window, extra row or security byte
   always_comb begin
      ld_ok = 1'b0;
      case (ss_q)
         `DFAC_SP_USER: ld_ok = !code_addr_in[15];
         `DFAC_SP_SPARE_INFO_ROW: ld_ok = in_spare_info_row;
         `DFAC_SP_SEC:  ld_ok = in_sec;
         default:       ld_ok = 1'b0;
      endcase
      // boot flash has no write path at all
      if (in_boot || ex_ext || !lmap_q || busy) begin
         ld_ok = 1'b0;
      end
   end

   assign lat_wr = code_req_in && code_we_in && ld_ok;
   assign deny   = code_req_in && (code_we_in ? !ld_ok : !rd_ok);

   always_comb begin
      rdata_d = rdata_q;
      if (code_req_in && !code_we_in) begin
         if (!rd_ok) begin
            rdata_d = 8'h00;
         end else if (in_sec) begin
            rdata_d = sec_q;
         end else if (in_boot) begin
            rdata_d = boot_rdata_in;
         end else begin
            rdata_d = main_rdata_in;
         end
      end
   end
   assign rd_boot_out  = in_boot;
   assign rd_space_out = in_spare_info_row ? `DFAC_SP_SPARE_INFO_ROW : (in_sec ? `DFAC_SP_SEC : `DFAC_SP_USER);

   // last loaded user page picks the programmed page
   always_comb begin
      page_d = page_q;
      if (lat_wr && ss_q == `DFAC_SP_USER) begin
         page_d = code_addr_in[14:7];
      end
   end

   // launch key: a second step only counts straight after the first
   always_comb begin
      ks_d   = ks_q;
      launch = 1'b0;
      case (ks_q)
         dfac_pkg::DFAC_KS_IDLE: begin
            if (ctrl_wr && key_in == `DFAC_KEY_ARM && !busy) begin
               ks_d = dfac_pkg::DFAC_KS_ARMED;
            end
         end
         dfac_pkg::DFAC_KS_ARMED: begin
            ks_d = dfac_pkg::DFAC_KS_IDLE;
            if (ctrl_wr && key_in == `DFAC_KEY_GO && !code_req_in) begin
               launch = 1'b1;
            end else if (ctrl_wr && key_in == `DFAC_KEY_ARM) begin
               ks_d = dfac_pkg::DFAC_KS_ARMED;
            end else if (!apb_acc && !code_req_in) begin
               ks_d = dfac_pkg::DFAC_KS_ARMED;
            end
         end
         default: ks_d = dfac_pkg::DFAC_KS_IDLE;
      endcase
   end

   // reserved space launches do nothing; wrong region or busy is refused
   assign start  = launch && ex_boot && !busy && (ss_q != `DFAC_SP_RSV);
   assign refuse = launch && (ss_q != `DFAC_SP_RSV) && (!ex_boot || busy);

   always_comb begin
      key_d    = key_q;
      lmap_d   = lmap_q;
      ss_d     = ss_q;
      mask_d   = mask_q;
      pspace_d = pspace_q;
      boot_map_enable_d = boot_map_enable_q;
      if (ctrl_wr) begin
         key_d  = key_in;
         lmap_d = pwdata_in[`DFAC_CTRL_LMAP];
         ss_d   = pwdata_in[`DFAC_CTRL_SS_HI:`DFAC_CTRL_SS_LO];
      end
      if (apb_wr && paddr_in == `DFAC_OFF_AUX) begin
         boot_map_enable_d = pwdata_in[`DFAC_AUX_BOOT];
      end else if (!strap_done_q) begin
         boot_map_enable_d = !boot_strap_in;
      end
      if (apb_wr && paddr_in == `DFAC_OFF_MASK) begin
         mask_d = pwdata_in[`DFAC_ST_W-1:0];
      end
      if (start) begin
         pspace_d = ss_q;
      end
   end

   // events beat a same-cycle write-one clear
   always_comb begin
      stat_d = stat_q;
      if (apb_wr && paddr_in == `DFAC_OFF_STAT) begin
         stat_d = stat_q & ~pwdata_in[`DFAC_ST_W-1:0];
      end
      if (done) begin
         stat_d[`DFAC_ST_DONE] = 1'b1;
      end
      if (refuse) begin
         stat_d[`DFAC_ST_REFUSE] = 1'b1;
      end
      if (deny) begin
         stat_d[`DFAC_ST_DENY] = 1'b1;
      end
   end
   assign irq_out = |(stat_q & mask_q);

   // software only reaches the upper nibble; the lock nibble is parallel-only
   always_comb begin
      sec_d = sec_q;
      if (par_sec_we_in) begin
         sec_d = par_sec_data_in;
      end else if (prog && pspace_q == `DFAC_SP_SEC && idx == 7'h00) begin
         sec_d = {lat_rdata[7:4], sec_q[3:0]};
      end
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         key_q    <= 4'h0;
         lmap_q   <= 1'b0;
         ss_q     <= `DFAC_SP_USER;
         pspace_q <= `DFAC_SP_USER;
         mask_q   <= '0;
         stat_q   <= '0;
         sec_q    <= `DFAC_SEC_RST;
         page_q   <= 8'h00;
         ks_q     <= dfac_pkg::DFAC_KS_IDLE;
         rdata_q  <= 8'h00;
         ack_q    <= 1'b0;
         deny_q   <= 1'b0;
         strap_done_q      <= 1'b0;
         boot_map_enable_q <= 1'b0;
      end else begin
         key_q    <= key_d;
         lmap_q   <= lmap_d;
         ss_q     <= ss_d;
         pspace_q <= pspace_d;
         mask_q   <= mask_d;
         stat_q   <= stat_d;
         sec_q    <= sec_d;
         page_q   <= page_d;
         ks_q     <= ks_d;
         rdata_q  <= rdata_d;
         ack_q    <= code_req_in;
         deny_q   <= deny;
         strap_done_q      <= 1'b1;
         boot_map_enable_q <= boot_map_enable_d;
      end
   end

   assign code_ack_out   = ack_q;
   assign code_deny_out  = deny_q;
   assign code_rdata_out = rdata_q;

   dfac_col_latch u_latch (
      .clock_in  (clock_in),
      .arst_n_in (arst_n_in),
      .wr_in     (lat_wr),
      .widx_in   (code_addr_in[6:0]),
      .wdata_in  (code_wdata_in),
      .clr_in    (done),
      .ridx_in   (idx),
      .rdata_out (lat_rdata),
      .valid_out (lat_valid)
   );

   dfac_prog_seq u_seq (
      .clock_in  (clock_in),
      .arst_n_in (arst_n_in),
      .start_in  (start),
      .valid_in  (lat_valid),
      .busy_out  (busy),
      .done_out  (done),
      .idx_out   (idx),
      .erase_out (erase),
      .prog_out  (prog)
   );

   // security byte is held here, so the array sees no strobes for it
   assign arr_erase_out = erase && (pspace_q != `DFAC_SP_SEC);
   assign arr_prog_out  = prog && (pspace_q != `DFAC_SP_SEC);
   assign arr_space_out = pspace_q;
   assign arr_page_out  = page_q;
   assign arr_off_out   = idx;
   assign arr_wdata_out = lat_rdata;
endmodule

// ### hw/dfac_map.svh
// offsets, field positions, codes and timing counts of the flash access block
`ifndef DFAC_MAP_SVH
`define DFAC_MAP_SVH
`define DFAC_OFF_CTRL   12'h000
`define DFAC_OFF_AUX    12'h004
`define DFAC_OFF_STAT   12'h008
`define DFAC_OFF_MASK   12'h00c
`define DFAC_OFF_SEC    12'h010
`define DFAC_CTRL_BUSY  0
`define DFAC_CTRL_SS_LO 1
`define DFAC_CTRL_SS_HI 2
`define DFAC_CTRL_LMAP  3
`define DFAC_CTRL_KEYLO 4
`define DFAC_CTRL_KEYHI 7
`define DFAC_AUX_BOOT   5
`define DFAC_ST_DONE    0
`define DFAC_ST_REFUSE  1
`define DFAC_ST_DENY    2
`define DFAC_ST_W       3
`define DFAC_KEY_ARM    4'h5
`define DFAC_KEY_GO     4'ha
`define DFAC_SP_USER    2'b00
`define DFAC_SP_SPARE_INFO_ROW    2'b01
`define DFAC_SP_SEC     2'b10
`define DFAC_SP_RSV     2'b11
`define DFAC_EX_MAIN    2'b00
`define DFAC_EX_BOOT    2'b01
`define DFAC_EX_EXT     2'b10
`define DFAC_BOOT_BASE  16'hf800
`define DFAC_SPARE_INFO_ROW_BASE  16'hff80
`define DFAC_SEC_ADDR   16'h0000
`define DFAC_PAGE_BYTES 128
`define DFAC_LOCK_MAX   4'h0
`define DFAC_SEC_RST    8'h00
`define DFAC_CLK_NS     40
`define DFAC_STEP_NS    160
`define DFAC_STEP_CYC   ((`DFAC_STEP_NS + `DFAC_CLK_NS - 1) / `DFAC_CLK_NS)
`endif

// ### hw/dfac_pkg.sv
// types of the flash access block
package dfac_pkg;
   typedef enum logic [1:0] {
      DFAC_KS_IDLE  = 2'b01,
      DFAC_KS_ARMED = 2'b10
   } dfac_key_t;
   typedef enum logic [3:0] {
      DFAC_SQ_IDLE  = 4'b0001,
      DFAC_SQ_SCAN  = 4'b0010,
      DFAC_SQ_ERASE = 4'b0100,
      DFAC_SQ_PROG  = 4'b1000
   } dfac_seq_t;
endpackage

// ### hw/dfac_col_latch.sv
// full-page column latch buffer with a loaded flag per byte
`timescale 1ns/10ps
`include "dfac_map.svh"
module dfac_col_latch (
   input  wire logic                          clock_in,
   input  wire logic                          arst_n_in,
   input  wire logic                          wr_in,
   input  wire logic [6:0]                    widx_in,
   input  wire logic [7:0]                    wdata_in,
   input  wire logic                          clr_in,
   input  wire logic [6:0]                    ridx_in,
   output logic      [7:0]                    rdata_out,
   output logic      [`DFAC_PAGE_BYTES-1:0]   valid_out
);
   logic [7:0] data_q [`DFAC_PAGE_BYTES];
   logic [7:0] data_d [`DFAC_PAGE_BYTES];
   logic [`DFAC_PAGE_BYTES-1:0] vld_d;
   logic [`DFAC_PAGE_BYTES-1:0] vld_q;

   genvar gi;
   generate
      for (gi = 0; gi < `DFAC_PAGE_BYTES; gi++) begin : g_ent
         // clear wins: a load never lands in the cycle that ends a page
         always_comb begin
            data_d[gi] = data_q[gi];
            vld_d[gi]  = vld_q[gi];
            if (clr_in) begin
               vld_d[gi] = 1'b0;
            end else if (wr_in && widx_in == 7'(gi)) begin
               data_d[gi] = wdata_in;
               vld_d[gi]  = 1'b1;
            end
         end
         always_ff @(posedge clock_in or negedge arst_n_in) begin
            if (!arst_n_in) begin
               data_q[gi] <= 8'h00;
               vld_q[gi]  <= 1'b0;
            end else begin
               data_q[gi] <= data_d[gi];
               vld_q[gi]  <= vld_d[gi];
            end
         end
      end
   endgenerate

   assign rdata_out = data_q[ridx_in];
   assign valid_out = vld_q;
endmodule

// ### hw/dfac_prog_seq.sv
// erase-then-program walk over the loaded column latch entries
`timescale 1ns/10ps
`include "dfac_map.svh"
module dfac_prog_seq (
   input  wire logic                          clock_in,
   input  wire logic                          arst_n_in,
   input  wire logic                          start_in,
   input  wire logic [`DFAC_PAGE_BYTES-1:0]   valid_in,
   output logic                               busy_out,
   output logic                               done_out,
   output logic      [6:0]                    idx_out,
   output logic                               erase_out,
   output logic                               prog_out
);
   localparam logic [7:0] STEP = 8'(`DFAC_STEP_CYC);
   dfac_pkg::dfac_seq_t st_q;
   dfac_pkg::dfac_seq_t st_d;
   logic [6:0] idx_q;
   logic [6:0] idx_d;
   logic [7:0] tmr_q;
   logic [7:0] tmr_d;
   logic       done_q;
   logic       done_d;

   always_comb begin
      st_d   = st_q;
      idx_d  = idx_q;
      tmr_d  = tmr_q;
      done_d = 1'b0;
      case (st_q)
         dfac_pkg::DFAC_SQ_IDLE: begin
            if (start_in) begin
               st_d  = dfac_pkg::DFAC_SQ_SCAN;
               idx_d = 7'h00;
            end
         end
         dfac_pkg::DFAC_SQ_SCAN: begin
            // only loaded locations are touched
            if (valid_in[idx_q]) begin
               st_d  = dfac_pkg::DFAC_SQ_ERASE;
               tmr_d = STEP;
            end else if (idx_q == 7'h7f) begin
               st_d   = dfac_pkg::DFAC_SQ_IDLE;
               done_d = 1'b1;
            end else begin
               idx_d = idx_q + 7'h01;
            end
         end
         dfac_pkg::DFAC_SQ_ERASE: begin
            tmr_d = tmr_q - 8'h01;
            if (tmr_q == 8'h01) begin
               st_d  = dfac_pkg::DFAC_SQ_PROG;
               tmr_d = STEP;
            end
         end
         dfac_pkg::DFAC_SQ_PROG: begin
            tmr_d = tmr_q - 8'h01;
            if (tmr_q == 8'h01) begin
               if (idx_q == 7'h7f) begin
                  st_d   = dfac_pkg::DFAC_SQ_IDLE;
                  done_d = 1'b1;
               end else begin
                  st_d  = dfac_pkg::DFAC_SQ_SCAN;
                  idx_d = idx_q + 7'h01;
               end
            end
         end
         default: st_d = dfac_pkg::DFAC_SQ_IDLE;
      endcase
   end

   always_ff @(posedge clock_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         st_q   <= dfac_pkg::DFAC_SQ_IDLE;
         idx_q  <= 7'h00;
         tmr_q  <= 8'h00;
         done_q <= 1'b0;
      end else begin
         st_q   <= st_d;
         idx_q  <= idx_d;
         tmr_q  <= tmr_d;
         done_q <= done_d;
      end
   end

   assign busy_out  = (st_q != dfac_pkg::DFAC_SQ_IDLE);
   assign done_out  = done_q;
   assign idx_out   = idx_q;
   assign erase_out = (st_q == dfac_pkg::DFAC_SQ_ERASE);
   assign prog_out  = (st_q == dfac_pkg::DFAC_SQ_PROG);
endmodule

// ### dv/dfac_monitor.sv
// concurrent checks on the flash access block ports
`timescale 1ns/10ps
`include "dfac_map.svh"
module dfac_monitor (
   input wire logic        clock_in,
   input wire logic        arst_n_in,
   input wire logic        code_req_in,
   input wire logic        code_we_in,
   input wire logic [15:0] code_addr_in,
   input wire logic [1:0]  exec_region_in,
   input wire logic        external_access_pin_in,
   input wire logic        code_ack_out,
   input wire logic        code_deny_out,
   input wire logic [7:0]  code_rdata_out,
   input wire logic        rd_boot_out,
   input wire logic        ext_exec_block_out,
   input wire logic        arr_erase_out,
   input wire logic        arr_prog_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!arst_n_in);
   property p_ack; code_req_in |=> code_ack_out; endproperty
   a_ack: assert property (p_ack) else $error("request without answer");
   property p_idle; !code_req_in |=> !code_ack_out && !code_deny_out; endproperty
   a_idle: assert property (p_idle) else $error("answer without request");
   property p_ext;
      code_req_in && exec_region_in == `DFAC_EX_EXT && !external_access_pin_in |=> code_deny_out;
   endproperty
   a_ext: assert property (p_ext) else $error("external access granted");
   property p_lock;
      code_req_in && exec_region_in == `DFAC_EX_EXT && ext_exec_block_out |=> code_deny_out;
   endproperty
   a_lock: assert property (p_lock) else $error("locked external access granted");
   property p_bootrd;
      code_req_in && !code_we_in && rd_boot_out && exec_region_in == `DFAC_EX_MAIN
         |=> code_deny_out;
   endproperty
   a_bootrd: assert property (p_bootrd) else $error("boot read from main");
   property p_bootwr; code_req_in && code_we_in && rd_boot_out |=> code_deny_out; endproperty
   a_bootwr: assert property (p_bootwr) else $error("boot flash load accepted");
   property p_window; rd_boot_out |-> code_addr_in >= `DFAC_BOOT_BASE; endproperty
   a_window: assert property (p_window) else $error("boot window misplaced");
   property p_zero;
      code_req_in && !code_we_in ##1 code_deny_out |-> code_rdata_out == 8'h00;
   endproperty
   a_zero: assert property (p_zero) else $error("denied read leaks data");
   // each loaded byte: four erase cycles, then four program cycles
   property p_step;
      $rose(arr_erase_out) |-> arr_erase_out[*4] ##1 arr_prog_out[*4] ##1 !arr_prog_out;
   endproperty
   a_step: assert property (p_step) else $error("erase then program walk wrong");
   property p_excl; !(arr_erase_out && arr_prog_out); endproperty
   a_excl: assert property (p_excl) else $error("erase and program overlap");
endmodule

// ### dv/dfac_flash_model.sv
// read data of the two flash arrays for the addressed byte
`timescale 1ns/10ps
module dfac_flash_model (
   input  wire logic [15:0] code_addr_in,
   output logic      [7:0]  main_rdata_out,
   output logic      [7:0]  boot_rdata_out
);
   // address-derived, so a wrong array choice shows
   assign main_rdata_out = code_addr_in[7:0] ^ code_addr_in[15:8];
   assign boot_rdata_out = ~(code_addr_in[7:0] ^ code_addr_in[15:8]);
endmodule

// ### dv/tb_top.sv
// self-checking bench of the flash access block
`timescale 1ns/10ps
`include "dfac_map.svh"
module tb_top;
   logic        clock_in, arst_n_in, psel_in, penable_in, pwrite_in, code_req_in;
   logic        code_we_in, external_access_pin_in, boot_strap_in, par_sec_we_in;
   logic        pready_out, pslverr_out, irq_out, code_ack_out, code_deny_out, err;
   logic        rd_boot_out, ext_exec_block_out, arr_erase_out, arr_prog_out, er_q;
   logic [11:0] paddr_in;
   logic [31:0] pwdata_in, prdata_out, rd;
   logic [15:0] code_addr_in;
   logic [7:0]  code_wdata_in, code_rdata_out, main_rdata_in, boot_rdata_in;
   logic [7:0]  par_sec_data_in, arr_page_out, arr_wdata_out;
   logic [6:0]  arr_off_out;
   logic [1:0]  exec_region_in, rd_space_out, arr_space_out;
   logic [16:0] log_q[$];
   int          bad_count, samples_checked, cycles;
   dfac_top i_dut (.clock_in, .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
      .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .irq_out, .code_req_in,
      .code_we_in, .code_addr_in, .code_wdata_in, .exec_region_in, .external_access_pin_in,
      .boot_strap_in, .code_ack_out, .code_deny_out, .code_rdata_out, .main_rdata_in,
      .boot_rdata_in, .rd_boot_out, .rd_space_out, .par_sec_we_in, .par_sec_data_in,
      .ext_exec_block_out, .arr_erase_out, .arr_prog_out, .arr_space_out, .arr_page_out,
      .arr_off_out, .arr_wdata_out);
   dfac_flash_model i_mem (.code_addr_in, .main_rdata_out(main_rdata_in),
      .boot_rdata_out(boot_rdata_in));
   initial begin
      clock_in = 1'b0;
      forever #20 clock_in = ~clock_in;
   end
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      er_q <= arr_erase_out;
      if (arr_erase_out && !er_q) log_q.push_back({arr_space_out, arr_page_out, arr_off_out});
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   task complete_run;
      if (bad_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clock_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clock_in);
      penable_in <= 1'b1;
      do @(posedge clock_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask
   // rd holds {ack, deny, data} of the answer one cycle on
   task cpu(input logic w, input logic [15:0] a, input logic [7:0] d);
      @(posedge clock_in);
      code_req_in <= 1'b1;
      code_we_in <= w;
      code_addr_in <= a;
      code_wdata_in <= d;
      @(posedge clock_in);
      code_req_in <= 1'b0;
      @(posedge clock_in);
      rd = {22'h0, code_ack_out, code_deny_out, code_rdata_out};
   endtask
   task launch(input logic [3:0] low);
      apb(1'b1, `DFAC_OFF_CTRL, {24'h0, `DFAC_KEY_ARM, low});
      apb(1'b1, `DFAC_OFF_CTRL, {24'h0, `DFAC_KEY_GO, low});
   endtask
   task wait_done;
      rd = 32'h0;
      for (int i = 0; i < 300 && rd[0] !== 1'b1; i++) apb(1'b0, `DFAC_OFF_STAT, 32'h0);
      chk(rd[0], 1'b1);
      apb(1'b1, `DFAC_OFF_STAT, 32'h7);
   endtask
   task t_reset;
      apb(1'b0, `DFAC_OFF_SEC, 32'h0);
      chk(rd, 32'h0);
      chk(ext_exec_block_out, 1'b1);
      apb(1'b0, `DFAC_OFF_AUX, 32'h0);
      chk(rd, 32'h20);
      apb(1'b0, 12'h0f0, 32'h0);
      chk({err, rd[30:0]}, 32'h80000000);
      apb(1'b1, `DFAC_OFF_AUX, 32'h0);
      cpu(1'b0, 16'hf900, 8'h00);
      chk(rd_boot_out, 1'b0);
      apb(1'b1, `DFAC_OFF_AUX, 32'h20);
   endtask
   task t_access;
      cpu(1'b0, 16'h1234, 8'h00);
      chk(rd, 32'h226);
      cpu(1'b0, 16'hf900, 8'h00);
      chk(rd, 32'h300);
      exec_region_in <= `DFAC_EX_BOOT;
      cpu(1'b0, 16'hf900, 8'h00);
      chk(rd, 32'h206);
      cpu(1'b1, 16'hf900, 8'h11);
      chk(rd[9:8], 2'b11);
      exec_region_in <= `DFAC_EX_EXT;
      cpu(1'b0, 16'h1234, 8'h00);
      chk(rd[9:8], 2'b11);
      external_access_pin_in <= 1'b1;
      cpu(1'b0, 16'h1234, 8'h00);
      chk(rd[9:8], 2'b11);
   endtask
   task t_prog;
      exec_region_in <= `DFAC_EX_BOOT;
      apb(1'b1, `DFAC_OFF_CTRL, 32'h08);
      cpu(1'b1, 16'h0105, 8'h3c);
      chk(rd[9:8], 2'b10);
      cpu(1'b1, 16'h0181, 8'hc3);
      launch(4'h8);
      apb(1'b0, `DFAC_OFF_CTRL, 32'h0);
      chk(rd[0], 1'b1);
      cpu(1'b1, 16'h0106, 8'h00);
      chk(rd[9:8], 2'b11);
      wait_done;
      apb(1'b0, `DFAC_OFF_CTRL, 32'h0);
      chk(rd[0], 1'b0);
      chk(log_q.size(), 2);
      chk(log_q[0], {2'b00, 8'h03, 7'h01});
      chk(log_q[1], {2'b00, 8'h03, 7'h05});
      log_q.delete();
   endtask
   task t_refuse;
      exec_region_in <= `DFAC_EX_MAIN;
      cpu(1'b1, 16'h0010, 8'h01);
      chk(rd[9:8], 2'b10);
      launch(4'h8);
      apb(1'b0, `DFAC_OFF_STAT, 32'h0);
      chk(rd[1], 1'b1);
      exec_region_in <= `DFAC_EX_BOOT;
      apb(1'b1, `DFAC_OFF_CTRL, 32'h58);
      apb(1'b0, `DFAC_OFF_CTRL, 32'h0);
      apb(1'b1, `DFAC_OFF_CTRL, 32'ha8);
      launch(4'he);
      repeat (200) @(posedge clock_in);
      chk(log_q.size(), 0);
      apb(1'b1, `DFAC_OFF_CTRL, 32'h0a);
      cpu(1'b1, 16'hff90, 8'h5a);
      chk({rd[9:8], rd_space_out}, 4'b1001);
      launch(4'ha);
      wait_done;
      chk({log_q[0][16:15], log_q[0][6:0]}, {2'b01, 7'h10});
      log_q.delete();
   endtask
   task t_sec;
      apb(1'b1, `DFAC_OFF_CTRL, 32'h0c);
      cpu(1'b1, 16'h0000, 8'hb7);
      launch(4'hc);
      wait_done;
      apb(1'b0, `DFAC_OFF_SEC, 32'h0);
      chk(rd, 32'hb0);
      chk(ext_exec_block_out, 1'b1);
      par_sec_we_in <= 1'b1;
      par_sec_data_in <= 8'h93;
      @(posedge clock_in);
      par_sec_we_in <= 1'b0;
      apb(1'b0, `DFAC_OFF_SEC, 32'h0);
      chk(rd, 32'h93);
      chk(ext_exec_block_out, 1'b0);
      exec_region_in <= `DFAC_EX_EXT;
      cpu(1'b0, 16'h1234, 8'h00);
      chk(rd, 32'h226);
   endtask
   task t_irq;
      apb(1'b1, `DFAC_OFF_STAT, 32'h7);
      apb(1'b1, `DFAC_OFF_MASK, 32'h4);
      external_access_pin_in <= 1'b0;
      cpu(1'b0, 16'h1234, 8'h00);
      @(posedge clock_in);
      chk(irq_out, 1'b1);
      apb(1'b1, `DFAC_OFF_MASK, 32'h0);
      @(posedge clock_in);
      chk(irq_out, 1'b0);
      apb(1'b1, `DFAC_OFF_MASK, 32'h4);
      apb(1'b1, `DFAC_OFF_STAT, 32'h4);
      @(posedge clock_in);
      chk(irq_out, 1'b0);
   endtask
   initial begin
      {arst_n_in, psel_in, penable_in, pwrite_in, code_req_in, code_we_in} = '0;
      {external_access_pin_in, boot_strap_in, par_sec_we_in} = '0;
      {paddr_in, pwdata_in, code_addr_in, code_wdata_in, par_sec_data_in} = '0;
      exec_region_in = `DFAC_EX_MAIN;
      repeat (2) @(posedge clock_in);
      arst_n_in <= 1'b1;
      t_reset;
      t_access;
      t_prog;
      t_refuse;
      t_sec;
      t_irq;
      complete_run();
   end
endmodule
bind dfac_top dfac_monitor i_mon (.clock_in, .arst_n_in, .code_req_in, .code_we_in,
   .code_addr_in, .exec_region_in, .external_access_pin_in, .code_ack_out, .code_deny_out,
   .code_rdata_out, .rd_boot_out, .ext_exec_block_out, .arr_erase_out, .arr_prog_out);
